// ---- design/xbps_pkg.sv ----
// constants for the on-chip peripheral bus select and decode block
package xbps_pkg;
    localparam int unsigned ADDR_W      = 24;
    localparam int unsigned SEL_W       = 11;
    // axi byte addresses of the registers
    localparam logic [15:0] OFS_SELECT  = 16'h0000;
    localparam logic [15:0] OFS_STATUS  = 16'h0004;
    localparam logic [15:0] OFS_WINDOW  = 16'hF01C;
    localparam logic [15:0] WINDOW_RST  = 16'h800B;
    localparam logic [15:0] SELECT_RST  = 16'h0000;
    // select bit positions
    localparam int unsigned B_FIRST_CAN_CONTROLLER      = 0;
    localparam int unsigned B_SECOND_CAN_CONTROLLER      = 1;
    localparam int unsigned B_RAM1      = 2;
    localparam int unsigned B_RAM2      = 3;
    localparam int unsigned B_CLOCK     = 4;
    localparam int unsigned B_PWM       = 6;
    localparam int unsigned B_ASYNC     = 7;
    localparam int unsigned B_SYNC      = 8;
    localparam int unsigned B_TWOWIRE   = 9;
    localparam int unsigned B_MISC      = 10;
    // writable select bits: 15:11 and 5 reserved
    localparam logic [15:0] SELECT_MASK = 16'h07DF;
    // shared group: every unit except the two ram blocks
    localparam logic [10:0] SHARED_MASK = 11'h7D3;
    // window register fields
    localparam int unsigned START_LSB   = 4;
    localparam int unsigned SIZE_MAX    = 11;
    // fixed ranges, A23..A11
    localparam logic [12:0] RAM1_BLK    = 13'h001C;
    localparam logic [12:0] SHARED_BLK  = 13'h001D;
    // status register layout
    localparam int unsigned ST_GLOBAL   = 16;
    localparam int unsigned ST_LOCK     = 17;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ---- design/xbps_decode.sv ----
// peripheral select register, ram window register and bus decode
`timescale 1ns/1ns
`default_nettype none
module xbps_decode
    import xbps_pkg::*;
#(
    parameter int unsigned AXI_ADDR_W = 16
) (
    input  wire logic                     clock,
    input  wire logic                     rst,
    // axi4-lite register port
    input  wire logic [AXI_ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [AXI_ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // core side
    input  wire logic                     onchip_bus_global_enable,
    input  wire logic                     end_of_init_instruction,
    input  wire logic                     acc_valid,
    input  wire logic [xbps_pkg::ADDR_W-1:0] acc_addr,
    // decode result, one cycle after acc_valid
    output logic                          dec_valid,
    output logic [xbps_pkg::SEL_W-1:0]    dec_claim,
    output logic                          dec_external,
    output logic                          dec_unclaimed,
    // ownership of pins and interrupts
    output logic [xbps_pkg::SEL_W-1:0]    unit_active,
    output logic                          misc_access_ok,
    output logic                          first_can_pins_claim,
    output logic                          second_can_pins_claim
);
    import xbps_pkg::*;

    // the register offsets are 16 bits wide, so a narrower bus cannot reach them
    if (AXI_ADDR_W < 16) begin : g_addr_check
        $error("AXI_ADDR_W must be at least 16");
    end

    function automatic logic [11:0] start_mask(input logic [3:0] size);
        start_mask = 12'hFFF << size;
    endfunction

    logic [15:0]       select_reg;
    logic [15:0]       window_reg;
    logic [SEL_W-1:0]  active_reg;
    logic              global_q_reg;
    logic              lock_reg;
    logic              aw_held_reg;
    logic              w_held_reg;
    logic [AXI_ADDR_W-1:0] awaddr_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;
    logic              dvalid_reg;
    logic [SEL_W-1:0]  claim_reg;
    logic              ext_reg;
    logic              void_reg;

    // ---------------- axi write path ----------------
    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire aw_have  = aw_held_reg || aw_take;
    wire w_have   = w_held_reg || w_take;
    wire wr_fire  = aw_have && w_have && !bvalid_reg;
    wire [AXI_ADDR_W-1:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0]   wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
    wire [3:0]    wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
    wire [15:0]   wr_ofs  = wr_addr[15:0];
    wire          hi_ok   = (wr_addr >> 16) == '0;
    wire          wr_sel  = wr_fire && hi_ok && wr_ofs == OFS_SELECT;
    wire          wr_win  = wr_fire && hi_ok && wr_ofs == OFS_WINDOW;
    wire          wr_stat = wr_fire && hi_ok && wr_ofs == OFS_STATUS;
    wire          wr_map  = wr_sel || wr_win || wr_stat;
    wire [15:0]   lane    = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    wire [15:0] select_next = (select_reg & ~lane) | (wr_data[15:0] & lane & SELECT_MASK);
    // once locked the window keeps its value; the write is still answered okay
    wire        win_wr_ok   = wr_win && !lock_reg && !end_of_init_instruction;
    wire [15:0] window_next = (window_reg & ~lane) | (wr_data[15:0] & lane);

    always_ff @(posedge clock) begin
        if (rst) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= '0;
            wstrb_reg   <= '0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            aw_held_reg <= aw_have && !wr_fire;
            w_held_reg  <= w_have && !wr_fire;
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            select_reg <= SELECT_RST;
            window_reg <= WINDOW_RST;
            lock_reg   <= 1'b0;
        end else begin
            if (wr_sel) begin
                select_reg <= select_next;
            end
            if (win_wr_ok) begin
                window_reg <= window_next;
            end
            if (end_of_init_instruction) begin
                lock_reg <= 1'b1;
            end
        end
    end

    // ---------------- enable snapshot ----------------
    // units count only if selected when the global enable rises; later select
    // writes do not move ranges that the core already treats as occupied
    wire global_rise = onchip_bus_global_enable && !global_q_reg;

    always_ff @(posedge clock) begin
        if (rst) begin
            global_q_reg <= 1'b0;
            active_reg   <= '0;
        end else begin
            global_q_reg <= onchip_bus_global_enable;
            if (!onchip_bus_global_enable) begin
                active_reg <= '0;
            end else if (global_rise) begin
                active_reg <= select_reg[SEL_W-1:0];
            end
        end
    end

    assign unit_active           = active_reg;
    assign misc_access_ok        = active_reg[B_MISC];
    assign first_can_pins_claim  = active_reg[B_FIRST_CAN_CONTROLLER];
    assign second_can_pins_claim = active_reg[B_SECOND_CAN_CONTROLLER];

    // ---------------- axi read path ----------------
    wire [15:0] rd_ofs  = s_axi_araddr[15:0];
    wire        rd_hi   = (s_axi_araddr >> 16) == '0;
    wire [31:0] status  = {14'h0000, lock_reg, onchip_bus_global_enable,
                           5'h00, active_reg};
    wire        rd_sel  = rd_hi && rd_ofs == OFS_SELECT;
    wire        rd_win  = rd_hi && rd_ofs == OFS_WINDOW;
    wire        rd_stat = rd_hi && rd_ofs == OFS_STATUS;
    wire [31:0] rd_val  = rd_sel  ? {16'h0000, select_reg} :
                          rd_win  ? {16'h0000, window_reg} :
                          rd_stat ? status : 32'h0000_0000;

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    always_ff @(posedge clock) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_val;
            rresp_reg  <= (rd_sel || rd_win || rd_stat) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ---------------- address decode ----------------
    wire [3:0]  win_size  = window_reg[3:0];
    wire [11:0] win_start = window_reg[15:START_LSB];
    wire [11:0] win_mask  = start_mask(win_size);
    wire        size_ok   = win_size <= SIZE_MAX[3:0];
    wire        win_hit   = acc_addr[23:20] == 4'h0 && size_ok
                            && ((acc_addr[19:8] ^ win_start) & win_mask) == 12'h000;
    wire        in_ram1   = acc_addr[23:11] == RAM1_BLK;
    wire        in_shared = acc_addr[23:11] == SHARED_BLK;
    // shared range carved into eight 256-byte slots, one per unit
    wire [2:0]  slot      = acc_addr[10:8];
    wire [SEL_W-1:0] slot_unit =
        slot == 3'd0 ? SEL_W'(1) << B_FIRST_CAN_CONTROLLER    :
        slot == 3'd1 ? SEL_W'(1) << B_SECOND_CAN_CONTROLLER    :
        slot == 3'd2 ? SEL_W'(1) << B_ASYNC   :
        slot == 3'd3 ? SEL_W'(1) << B_SYNC    :
        slot == 3'd4 ? SEL_W'(1) << B_TWOWIRE :
        slot == 3'd5 ? SEL_W'(1) << B_PWM     :
        slot == 3'd6 ? SEL_W'(1) << B_CLOCK   : SEL_W'(1) << B_MISC;
    wire        group_on  = (active_reg & SHARED_MASK) != '0;
    wire [SEL_W-1:0] shared_claim = slot_unit & active_reg;
    wire        ram1_on   = active_reg[B_RAM1];
    wire        ram2_on   = active_reg[B_RAM2];

    logic [SEL_W-1:0] claim_next;
    logic             ext_next;
    logic             void_next;

    always_comb begin
        claim_next = '0;
        ext_next   = 1'b0;
        void_next  = 1'b0;
        if (in_ram1) begin
            claim_next[B_RAM1] = ram1_on;
            ext_next           = !ram1_on;
        end else if (in_shared) begin
            // units of one group share a bus config pair: with any unit on,
            // the range stays internal and a disabled slot reaches no one
            claim_next = shared_claim;
            ext_next   = !group_on;
            void_next  = group_on && shared_claim == '0;
        end else if (win_hit) begin
            claim_next[B_RAM2] = ram2_on;
            ext_next           = !ram2_on;
        end else begin
            ext_next = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            dvalid_reg <= 1'b0;
            claim_reg  <= '0;
            ext_reg    <= 1'b0;
            void_reg   <= 1'b0;
        end else begin
            dvalid_reg <= acc_valid;
            claim_reg  <= acc_valid ? claim_next : '0;
            ext_reg    <= acc_valid && ext_next;
            void_reg   <= acc_valid && void_next;
        end
    end

    assign dec_valid     = dvalid_reg;
    assign dec_claim     = claim_reg;
    assign dec_external  = ext_reg;
    assign dec_unclaimed = void_reg;

    // ---------------- checks ----------------
    a_window_locked: assert property (@(posedge clock) disable iff (rst)
        lock_reg |=> $stable(window_reg))
        else $error("window register changed after end of init");

    a_shared_external: assert property (@(posedge clock) disable iff (rst)
        acc_valid && in_shared
        |=> dec_external == $past((active_reg & SHARED_MASK) == '0))
        else $error("shared range external decision wrong");

    a_ram1_redirect: assert property (@(posedge clock) disable iff (rst)
        acc_valid && acc_addr[23:11] == 13'h001C && !active_reg[B_RAM1]
        |=> dec_external && dec_claim == '0)
        else $error("first ram range not sent external");

    a_ram2_enabled: assert property (@(posedge clock) disable iff (rst)
        acc_valid && !in_ram1 && !in_shared && win_hit
        |=> dec_claim[B_RAM2] == !dec_external)
        else $error("second ram window claim and external disagree");

    a_window_upper: assert property (@(posedge clock) disable iff (rst)
        acc_valid && acc_addr[23:20] != 4'h0 && !in_ram1 && !in_shared
        |=> dec_external)
        else $error("window hit above first megabyte");

    a_size_reserved: assert property (@(posedge clock) disable iff (rst)
        acc_valid && window_reg[3:2] == 2'b11 && !in_ram1 && !in_shared
        |=> !dec_claim[B_RAM2])
        else $error("reserved size code produced a hit");

    a_snapshot_hold: assert property (@(posedge clock) disable iff (rst)
        onchip_bus_global_enable && global_q_reg ##1 onchip_bus_global_enable
        |-> $stable(active_reg))
        else $error("active units changed while bus enabled");

    a_can_pins: assert property (@(posedge clock) disable iff (rst)
        !select_reg[B_SECOND_CAN_CONTROLLER] && global_rise |=> !second_can_pins_claim)
        else $error("unselected second can claimed pins");

    a_misc_gate: assert property (@(posedge clock) disable iff (rst)
        !onchip_bus_global_enable |=> !misc_access_ok)
        else $error("misc reachable without global enable");

    a_reserved_bits: assert property (@(posedge clock) disable iff (rst)
        wr_sel |=> (select_reg & ~SELECT_MASK) == 16'h0000)
        else $error("reserved select bits stored");

    a_bvalid_hold: assert property (@(posedge clock) disable iff (rst)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");

    a_read_hold: assert property (@(posedge clock) disable iff (rst)
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped before taken");

    a_ram1_claim: assert property (@(posedge clock) disable iff (rst)
        acc_valid && in_ram1 && active_reg[B_RAM1]
        |=> !dec_external && dec_claim == (SEL_W'(1) << B_RAM1))
        else $error("enabled first ram not claimed");

    a_shared_void: assert property (@(posedge clock) disable iff (rst)
        acc_valid && in_shared && group_on && shared_claim == '0
        |=> dec_unclaimed && !dec_external && dec_claim == '0)
        else $error("disabled unit in active group sent external");
endmodule // xbps_decode
`default_nettype wire

// ---- test/xbps_core_model.sv ----
// core-side model: issues decode accesses, global enable and end of init
`timescale 1ns/1ns
`default_nettype none
module xbps_core_model (
    input  wire logic   clock,
    output logic        acc_valid,
    output logic [23:0] acc_addr,
    output logic        onchip_bus_global_enable,
    output logic        end_of_init_instruction
);
    initial begin
        acc_valid = 1'b0;
        acc_addr = 24'h000000;
        onchip_bus_global_enable = 1'b0;
        end_of_init_instruction = 1'b0;
    end
    task automatic issue(input logic [23:0] a);
        acc_valid <= 1'b1;
        acc_addr <= a;
        @(posedge clock);
    endtask
    // a released address is inverted once per idle call so a stale value never decodes by luck
    task automatic idle();
        acc_valid <= 1'b0;
        acc_addr <= ~acc_addr;
        @(posedge clock);
    endtask
    // callers write select and window before the enable rises, misc only after
    task automatic set_glob(input logic v);
        onchip_bus_global_enable <= v;
        repeat (2) @(posedge clock);
    endtask
    task automatic pulse_eoi();
        end_of_init_instruction <= 1'b1;
        @(posedge clock);
        end_of_init_instruction <= 1'b0;
        @(posedge clock);
    endtask
endmodule // xbps_core_model
`default_nettype wire

// ---- test/tb_xbps_decode.sv ----
// self-checking bench for the peripheral select and decode block
`timescale 1ns/1ns
`default_nettype none
module tb_xbps_decode;
    import xbps_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] awaddr = 16'h0;
    logic [15:0] araddr = 16'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic [3:0]  strb_sel = 4'h3;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, glob, eoi, acc_valid;
    logic        dec_valid, dec_external, dec_unclaimed, misc_ok, first_can_controller_pins, second_can_controller_pins;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [23:0] acc_addr;
    logic [10:0] dec_claim, unit_active, ua_m;
    logic [15:0] sel_m, win_m;
    logic [12:0] pend;
    logic        lock_m, gprev, pend_v;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          slot_bit [8] = '{0, 1, 7, 8, 9, 6, 4, 10};
    logic [15:0] cfg [6] = '{16'h0000, 16'h0004, 16'h0008, 16'h07DF, 16'h0010, 16'h0400};

    always #5 clock = ~clock;

    xbps_decode u_dut (
        .clock(clock), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .onchip_bus_global_enable(glob), .end_of_init_instruction(eoi),
        .acc_valid(acc_valid), .acc_addr(acc_addr), .dec_valid(dec_valid),
        .dec_claim(dec_claim), .dec_external(dec_external), .dec_unclaimed(dec_unclaimed),
        .unit_active(unit_active), .misc_access_ok(misc_ok),
        .first_can_pins_claim(first_can_controller_pins), .second_can_pins_claim(second_can_controller_pins)
    );
    xbps_core_model u_core (
        .clock(clock), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .onchip_bus_global_enable(glob), .end_of_init_instruction(eoi)
    );

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // result packed as {claim, external, unclaimed}; fixed ranges win over the window
    function automatic logic [12:0] model_dec(input logic [23:0] a);
        logic [11:0] m;
        logic [10:0] c;
        c = 11'h0;
        m = 12'hFFF << win_m[3:0];
        if (a[23:11] == RAM1_BLK) begin
            c[B_RAM1] = ua_m[B_RAM1];
            return {c, !ua_m[B_RAM1], 1'b0};
        end
        if (a[23:11] == SHARED_BLK) begin
            if ((ua_m & SHARED_MASK) == 11'h0) return {c, 2'b10};
            c[slot_bit[a[10:8]]] = ua_m[slot_bit[a[10:8]]];
            return {c, 1'b0, c == 11'h0};
        end
        if (a[23:20] == 4'h0 && win_m[3:2] != 2'b11 && ((a[19:8] ^ win_m[15:4]) & m) == 12'h0) begin
            c[B_RAM2] = ua_m[B_RAM2];
            return {c, !ua_m[B_RAM2], 1'b0};
        end
        return {c, 2'b10};
    endfunction

    always @(posedge clock) begin
        if (rst) begin
            ua_m = 11'h0;
            gprev = 1'b0;
            pend_v = 1'b0;
            pend = 13'h0;
        end else begin
            pend_v = acc_valid;
            pend = acc_valid ? model_dec(acc_addr) : 13'h0;
            if (!glob) ua_m = 11'h0;
            else if (!gprev) ua_m = sel_m[10:0];
            gprev = glob;
        end
    end

    always @(negedge clock) begin
        if (!rst) begin
            check("dec_valid", 32'(dec_valid), 32'(pend_v));
            check("dec_claim", 32'(dec_claim), 32'(pend[12:2]));
            check("dec_external", 32'(dec_external), 32'(pend[1]));
            check("dec_unclaimed", 32'(dec_unclaimed), 32'(pend[0]));
            check("unit_active", 32'(unit_active), 32'(ua_m));
            check("pins", 32'({misc_ok, second_can_controller_pins, first_can_controller_pins}),
                  32'({ua_m[B_MISC], ua_m[B_SECOND_CAN_CONTROLLER], ua_m[B_FIRST_CAN_CONTROLLER]}));
        end
    end

    task automatic axi_write(input logic [15:0] a, input logic [15:0] d, input logic [1:0] er);
        logic at, wt, bt;
        logic [1:0] r;
        logic [15:0] ln;
        ln = {{8{strb_sel[1]}}, {8{strb_sel[0]}}};
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {16'h0, d};
        wstrb <= strb_sel;
        wvalid <= 1'b1;
        bready <= 1'b1;
        bt = 1'b0;
        // no cycle limit here: only the watchdog ends a hung response
        while (!bt) begin
            @(negedge clock);
            at = awvalid && awready;
            wt = wvalid && wready;
            bt = bvalid && bready;
            r = bresp;
            @(posedge clock);
            if (at) awvalid <= 1'b0;
            if (wt) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        check("bresp", 32'(r), 32'(er));
        if (er == RESP_OKAY && a == OFS_SELECT) sel_m = (sel_m & ~ln) | (d & ln & SELECT_MASK);
        if (er == RESP_OKAY && a == OFS_WINDOW && !lock_m) win_m = (win_m & ~ln) | (d & ln);
        @(posedge clock);
    endtask

    task automatic axi_read(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er,
                            input string nm);
        logic at, rt;
        logic [31:0] d;
        logic [1:0] r;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rt = 1'b0;
        while (!rt) begin
            @(negedge clock);
            at = arvalid && arready;
            rt = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clock);
            if (at) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        check(nm, d, ed);
        check("rresp", 32'(r), 32'(er));
        @(posedge clock);
    endtask

    initial begin
        #200000;
        miscompares++;
        finish_test();
    end

    initial begin
        sel_m = SELECT_RST;
        win_m = WINDOW_RST;
        lock_m = 1'b0;
        void'($urandom(16349));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        axi_read(OFS_SELECT, 32'h0, RESP_OKAY, "select");
        axi_read(OFS_WINDOW, 32'(WINDOW_RST), RESP_OKAY, "window");
        axi_read(16'h0008, 32'h0, RESP_SLVERR, "unmapped");
        axi_write(16'h0010, 16'hFFFF, RESP_SLVERR);
        axi_write(OFS_SELECT, 16'hFFFF, RESP_OKAY);
        axi_read(OFS_SELECT, 32'h000007DF, RESP_OKAY, "select");
        // low byte lane only: the upper select bits must survive
        strb_sel = 4'h1;
        axi_write(OFS_SELECT, 16'h0000, RESP_OKAY);
        axi_read(OFS_SELECT, 32'h00000700, RESP_OKAY, "select_lane");
        strb_sel = 4'h3;
        axi_write(OFS_SELECT, 16'hFFFF, RESP_OKAY);
        u_core.set_glob(1'b1);
        // select changes after the rise must not reach the snapshot
        axi_write(OFS_SELECT, 16'h0000, RESP_OKAY);
        // status is read-only: a write is answered but changes nothing
        axi_write(OFS_STATUS, 16'hFFFF, RESP_OKAY);
        axi_read(OFS_STATUS, 32'h000107DF, RESP_OKAY, "status");
        u_core.set_glob(1'b0);
        for (int i = 0; i < 20; i++) begin
            logic [15:0] w;
            logic [23:0] a;
            w = 16'($urandom);
            w[3:0] = i[3:0];
            if (w[15:10] == 6'h03) w[15] = 1'b1;
            if (i == 16) w = 16'h0806;
            axi_write(OFS_WINDOW, w, RESP_OKAY);
            axi_write(OFS_SELECT, i < 6 ? cfg[i] : 16'($urandom) & SELECT_MASK, RESP_OKAY);
            u_core.set_glob(1'b1);
            repeat (24) begin
                case ($urandom % 4)
                    0: a = {RAM1_BLK, 11'($urandom)};
                    1: a = {SHARED_BLK, 11'($urandom)};
                    2: a = {4'h0, w[15:4], 8'h00} | (24'($urandom) & ~{4'hF, 12'hFFF << w[3:0], 8'h00});
                    default: a = 24'($urandom);
                endcase
                u_core.issue(a);
            end
            u_core.idle();
            u_core.set_glob(1'b0);
        end
        axi_write(OFS_WINDOW, 16'h0806, RESP_OKAY);
        u_core.pulse_eoi();
        lock_m = 1'b1;
        axi_write(OFS_WINDOW, 16'hF006, RESP_OKAY);
        axi_read(OFS_WINDOW, 32'h00000806, RESP_OKAY, "window");
        axi_read(OFS_STATUS, 32'h00020000, RESP_OKAY, "status");
        finish_test();
    end
endmodule // tb_xbps_decode
`default_nettype wire
